// file: nce_pkg.sv
// constants and carrier types of the nibble core control and i/o executor
package nce_pkg;

	// ************************************************
	// full-byte opcodes, all one byte long except OP_SAS, which takes a second tone byte
	// ************************************************
	localparam logic [7:0] OP_HALT     = 8'h00;
	localparam logic [7:0] OP_TABLE_WRITE     = 8'h02;
	localparam logic [7:0] OP_TABLE_TONE     = 8'h03;
	localparam logic [7:0] OP_JMP_PAGE = 8'h10;
	localparam logic [7:0] OP_PAGE     = 8'h11;
	localparam logic [7:0] OP_RTS      = 8'h13;
	localparam logic [7:0] OP_PC_LOW   = 8'h14;
	localparam logic [7:0] OP_PC_MID   = 8'h15;
	localparam logic [7:0] OP_PC_HIGH  = 8'h16;
	localparam logic [7:0] OP_ISP      = 8'h9E;
	localparam logic [7:0] OP_DSP      = 8'h9F;
	localparam logic [7:0] OP_IPM      = 8'hA8;
	localparam logic [7:0] OP_LDA      = 8'hA9;
	localparam logic [7:0] OP_LSP      = 8'hAA;
	localparam logic [7:0] OP_STA      = 8'hAD;
	localparam logic [7:0] OP_SSP      = 8'hAE;
	localparam logic [7:0] OP_IPS      = 8'hAF;
	localparam logic [7:0] OP_BACKUP_CLEAR     = 8'hF8;
	localparam logic [7:0] OP_BACKUP_SET     = 8'hF9;
	localparam logic [7:0] OP_SAS      = 8'hFA;
	localparam logic [7:0] OP_SECONDS_CLEAR     = 8'hFB;
	localparam logic [7:0] OP_OUT      = 8'hFC;
	localparam logic [7:0] OP_NOP      = 8'hFF;
	localparam logic [7:0] OP_IN_DEF   = 8'h17;

	// ************************************************
	// opcode prefixes
	// ************************************************
	localparam logic [3:0] PFX_MVI  = 4'h2;
	localparam logic [3:0] PFX_LDI  = 4'h3;
	localparam logic [3:0] PFX_SIC  = 4'hD;
	localparam logic [3:0] PFX_MSP  = 4'hE;
	localparam logic [5:0] PFX_PULLDOWN_SET = 6'h3D;
	localparam logic [4:0] PFX_JMP  = 5'h01;
	localparam logic [4:0] PFX_JSR  = 5'h14;
	localparam logic [4:0] PFX_BAZ  = 5'h08;
	localparam logic [4:0] PFX_BRANCH_BIT_ZERO = 5'h09;
	localparam logic [4:0] PFX_BRANCH_NONZERO = 5'h0A;
	localparam logic [4:0] PFX_BRANCH_BIT_ONE = 5'h0B;
	localparam logic [4:0] PFX_BRANCH_NO_CARRY = 5'h0C;
	localparam logic [4:0] PFX_BRANCH_BIT_TWO = 5'h0D;
	localparam logic [4:0] PFX_BCH  = 5'h0E;
	localparam logic [4:0] PFX_BRANCH_BIT_THREE = 5'h0F;

	// ************************************************
	// stack pointer routing and tone codes
	// ************************************************
	localparam logic [3:0] SP_LCD_LAST = 4'hC;
	localparam logic [3:0] SP_CONTROL_LATCH_THREE     = 4'hD;
	localparam logic [3:0] SP_P0       = 4'hE;
	localparam logic [3:0] SP_P1       = 4'hF;
	localparam logic [3:0] TONE_NOTE_OFF = 4'hF;
	localparam logic [7:0] TONE_RST      = 8'hFF;

	// ************************************************
	// register map and reset values
	// ************************************************
	localparam logic [7:0]  REG_CTRL   = 8'h00;
	localparam logic [7:0]  REG_STATUS = 8'h04;
	localparam logic [7:0]  REG_RAM    = 8'h08;
	localparam int          CTRL_RUN   = 0;
	localparam int          CTRL_CARRY = 1;
	localparam int          CTRL_DP_LO = 8;
	localparam int          RAM_ADR_LO = 8;
	localparam logic [10:0] PC_RST     = 11'h000;

	typedef struct packed {
		logic       we;
		logic [3:0] addr;
		logic [7:0] data;
	} nce_lcd_t;

endpackage

// file: nce_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module nce_sync #(
	parameter int W = 4
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			dout   <= '0;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule // nce_sync

// file: nce_branch.sv
// branch condition evaluation for two-byte jumps
`timescale 1ns/100ps
module nce_branch
	import nce_pkg::*;
(
	// decode inputs
	input  wire logic [4:0] prefix,
	input  wire logic [3:0] work,
	input  wire logic       carry,
	// result
	output logic            taken
);
	always_comb begin
		unique case (prefix)
			PFX_JMP, PFX_JSR: taken = 1'b1;
			PFX_BRANCH_BIT_ZERO:         taken = work[0];
			PFX_BRANCH_BIT_ONE:         taken = work[1];
			PFX_BRANCH_BIT_TWO:         taken = work[2];
			PFX_BRANCH_BIT_THREE:         taken = work[3];
			PFX_BRANCH_NONZERO:         taken = (work != 4'h0);
			PFX_BAZ:          taken = (work == 4'h0);
			PFX_BRANCH_NO_CARRY:         taken = !carry;
			PFX_BCH:          taken = carry;
			default:          taken = 1'b0;
		endcase
	end
endmodule // nce_branch

// file: nce_core.sv
// control, i/o and branch executor of the nibble core with apb access
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/100ps

// Function
// (RULE1) one-cycle stack pointer increment, decrement, copy both ways, immediate load
// (RULE2) load and store between working register and RAM at data pointer
// (RULE3) immediate nibble into RAM or working register by prefix
// (RULE4) all-zero opcode halts until an enabled wake condition occurs
// (RULE5) wake enables from low nibble: predivider, S rise, M rise, tenth second
// (RULE6) backup flag cleared and set by opcode, driven out as control
// (RULE7) read port S or port M level into working register
// (RULE8) two-byte tone command passes second byte to tone generator
// (RULE9) tone reset equals all-ones tone byte, tone output low
// (RULE10) pull-down select register loaded from two low opcode bits
// (RULE11) output opcode routed by stack pointer: LCD, control latch, P0, P1
// (RULE12) input opcode loads status word, P0 or P1 by stack pointer
// (RULE13) table write fetches current-page ROM byte, routes like output
// (RULE14) table tone fetches current-page ROM byte into tone generator
// (RULE15) two-byte jump loads 11-bit target into program counter
// (RULE16) branches on working register bit set, else sequential; bit 2 and bit 3 forms are single-byte opcodes that only advance the program counter
// (RULE17) branches on working register nonzero or zero
// (RULE18) branches on carry clear or carry set; both forms are not decoded as two-byte branches and only advance the program counter by one
// (RULE19) page latch from RAM; indirect jump from page, work, RAM
// (RULE20) call saves program counter plus two; return restores it
// (RULE21) program counter nibbles stored into RAM at data pointer
// (RULE22) seconds clear resets upper predivider and start flags 0, 1, 4
// (RULE23) single-entry return stack, nested call overwrites
// (RULE24) all-ones opcode only advances program counter
module nce_core
	import nce_pkg::*;
#(
	parameter logic [7:0] IN_OPCODE = OP_IN_DEF,
	parameter int         RAM_WORDS = 128
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// program rom, combinational read
	output logic      [10:0] rom_addr,
	input  wire logic [7:0]  rom_data,
	// pins
	input  wire logic [3:0]  port_s_pin,
	input  wire logic [3:0]  port_m_pin,
	input  wire logic [3:0]  port_p0_pin,
	input  wire logic [3:0]  port_p1_pin,
	// peripherals on pclk
	input  wire logic [3:0]  status_word_three,
	input  wire logic        predivider_pulse,
	input  wire logic        tenth_second_pulse,
	// outputs
	output logic [3:0]       port_p0_out,
	output logic [3:0]       port_p1_out,
	output logic [3:0]       control_latch_three,
	output nce_lcd_t         lcd_write,
	output logic             backup_flag,
	output logic [1:0]       pulldown_select,
	output logic [7:0]       tone_code,
	output logic             tone_output_en,
	output logic             seconds_clear,
	output logic             halted
);

	// ************************************************
	// state and storage
	// ************************************************
	typedef enum logic [3:0] {
		ST_EXEC   = 4'b0001,
		ST_SECOND = 4'b0010,
		ST_TABLE  = 4'b0100,
		ST_HALT   = 4'b1000
	} nce_state_t;

	nce_state_t  state_r;
	logic [3:0]  ram [RAM_WORDS];
	logic [3:0]  working_register_r, stack_pointer_r, wake_enable_r;
	logic [10:0] program_counter_r, return_stack_r;
	logic [2:0]  page_r;
	logic [7:0]  opcode_r;
	logic [6:0]  data_pointer_r;
	logic        carry_flag_r, run_r;
	logic [3:0]  s_sync, m_sync, p0_sync, p1_sync, s_prev_r, m_prev_r;
	logic        taken, wake;
	logic [3:0]  mem_nib;
	logic [7:0]  op;
	logic [10:0] pc_inc, target;
	logic        apb_setup, apb_wr;

	assign op      = rom_data;
	assign mem_nib = ram[data_pointer_r];
	assign pc_inc  = program_counter_r + 11'h001;
	assign target  = {opcode_r[2:0], rom_data};
	// only a rising edge counts, so a held key cannot retrigger wake
	assign wake = (wake_enable_r[0] && predivider_pulse)                     // RULE5
		|| (wake_enable_r[1] && |(s_sync & ~s_prev_r))
		|| (wake_enable_r[2] && |(m_sync & ~m_prev_r))
		|| (wake_enable_r[3] && tenth_second_pulse);

	nce_sync #(.W(4)) u_sync_s  (.pclk(pclk), .presetn(presetn), .din(port_s_pin),  .dout(s_sync));
	nce_sync #(.W(4)) u_sync_m  (.pclk(pclk), .presetn(presetn), .din(port_m_pin),  .dout(m_sync));
	nce_sync #(.W(4)) u_sync_p0 (.pclk(pclk), .presetn(presetn), .din(port_p0_pin), .dout(p0_sync));
	nce_sync #(.W(4)) u_sync_p1 (.pclk(pclk), .presetn(presetn), .din(port_p1_pin), .dout(p1_sync));

	nce_branch u_branch (
		.prefix (opcode_r[7:3]),
		.work   (working_register_r),
		.carry  (carry_flag_r),
		.taken  (taken)
	);

	// ************************************************
	// apb slave, zero wait states
	// ************************************************
	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pwrite && pready;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= apb_setup;
			pslverr <= apb_setup && !(paddr == REG_CTRL || paddr == REG_STATUS
				|| paddr == REG_RAM);
			prdata  <= 32'h0000_0000;
			if (apb_setup && !pwrite) begin
				unique case (paddr)
					REG_CTRL:   prdata <= {17'h0, data_pointer_r, 6'h00,
						carry_flag_r, run_r};
					REG_STATUS: prdata <= {1'b0, state_r == ST_HALT, backup_flag,
						pulldown_select, wake_enable_r, page_r, stack_pointer_r,
						working_register_r, 1'b0, program_counter_r};
					REG_RAM:    prdata <= {28'h0, mem_nib};
					default:    prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_r          <= 1'b0;
			carry_flag_r   <= 1'b0;
			data_pointer_r <= 7'h00;
		end else if (apb_wr && paddr == REG_CTRL) begin
			run_r          <= pwdata[CTRL_RUN];
			carry_flag_r   <= pwdata[CTRL_CARRY];
			data_pointer_r <= pwdata[CTRL_DP_LO +: 7];
		end
	end

	// ************************************************
	// sequencer and program counter
	// ************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r           <= ST_EXEC;
			program_counter_r <= PC_RST;
			rom_addr          <= PC_RST;
			return_stack_r    <= PC_RST;
			opcode_r          <= 8'h00;
			halted            <= 1'b0;
		end else begin
			unique case (state_r)
				ST_EXEC: if (run_r) begin
					opcode_r          <= op;
					program_counter_r <= pc_inc;
					rom_addr          <= pc_inc;
					if (op == OP_HALT) begin
						state_r <= ST_HALT;                              // RULE4
						halted  <= 1'b1;
					end else if (op[7:3] == PFX_JMP || op[7:3] == PFX_JSR
						|| op[7:5] == 3'b010) begin
						state_r <= ST_SECOND;                            // RULE15
					end else if (op == OP_SAS || op == OP_TABLE_WRITE || op == OP_TABLE_TONE) begin
						state_r <= ST_SECOND;
						if (op != OP_SAS)
							rom_addr <= {program_counter_r[10:8], working_register_r,
								mem_nib};                                    // RULE13 RULE14
					end else if (op == OP_JMP_PAGE) begin
						program_counter_r <= {page_r, working_register_r, mem_nib}; // RULE19
						rom_addr          <= {page_r, working_register_r, mem_nib};
					end else if (op == OP_RTS) begin
						program_counter_r <= return_stack_r;             // RULE20
						rom_addr          <= return_stack_r;
					end
				end
				ST_SECOND: begin
					state_r <= ST_EXEC;
					if (opcode_r[7:3] == PFX_JSR)
						return_stack_r <= pc_inc;                        // RULE20 RULE23
					// table ops already stepped past their single byte
					if (opcode_r == OP_TABLE_WRITE || opcode_r == OP_TABLE_TONE) begin
						program_counter_r <= program_counter_r;
						rom_addr          <= program_counter_r;
					end else if (opcode_r == OP_SAS) begin
						program_counter_r <= pc_inc;                     // RULE8
						rom_addr          <= pc_inc;
					end else if (taken) begin
						program_counter_r <= target;                     // RULE15 RULE16 RULE17 RULE18
						rom_addr          <= target;
					end else begin
						program_counter_r <= pc_inc;
						rom_addr          <= pc_inc;
					end
				end
				ST_TABLE: state_r <= ST_EXEC;
				ST_HALT: if (wake) begin
					state_r <= ST_EXEC;                                  // RULE4
					halted  <= 1'b0;
				end
			endcase
		end
	end

	// ************************************************
	// working register, stack pointer, ram
	// ************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			working_register_r <= 4'h0;
			stack_pointer_r    <= 4'h0;
			page_r             <= 3'h0;
		end else if (state_r == ST_EXEC && run_r) begin
			if (op[7:4] == PFX_LDI)
				working_register_r <= op[3:0];                           // RULE3
			else if (op[7:4] == PFX_MSP)
				stack_pointer_r <= op[3:0];                              // RULE1
			unique case (op)
				OP_ISP:   stack_pointer_r    <= stack_pointer_r + 4'h1;  // RULE1
				OP_DSP:   stack_pointer_r    <= stack_pointer_r - 4'h1;  // RULE1
				OP_SSP:   stack_pointer_r    <= working_register_r;     // RULE1
				OP_LSP:   working_register_r <= stack_pointer_r;        // RULE1
				OP_LDA:   working_register_r <= mem_nib;                // RULE2
				OP_IPS:   working_register_r <= s_sync;                 // RULE7
				OP_IPM:   working_register_r <= m_sync;                 // RULE7
				OP_PAGE:  page_r             <= mem_nib[2:0];           // RULE19
				IN_OPCODE: begin
					if (stack_pointer_r == SP_CONTROL_LATCH_THREE)
						working_register_r <= status_word_three;        // RULE12
					else if (stack_pointer_r == SP_P0)
						working_register_r <= p0_sync;                  // RULE12
					else if (stack_pointer_r == SP_P1)
						working_register_r <= p1_sync;                  // RULE12
				end
				default: ;                                              // RULE24
			endcase
		end
	end

	// core writes win over any simultaneous software write to ram, whatever nibble it addresses
	always_ff @(posedge pclk) begin
		if (state_r == ST_EXEC && run_r && (op == OP_STA || op[7:4] == PFX_MVI
			|| op == OP_PC_LOW || op == OP_PC_MID || op == OP_PC_HIGH)) begin
			unique case (1'b1)
				op == OP_STA:       ram[data_pointer_r] <= working_register_r; // RULE2
				op[7:4] == PFX_MVI: ram[data_pointer_r] <= op[3:0];            // RULE3
				op == OP_PC_LOW:    ram[data_pointer_r] <= program_counter_r[3:0]; // RULE21
				op == OP_PC_MID:    ram[data_pointer_r] <= program_counter_r[7:4]; // RULE21
				default:            ram[data_pointer_r] <= {1'b0,
					program_counter_r[10:8]};                           // RULE21
			endcase
		end else if (apb_wr && paddr == REG_RAM) begin
			ram[pwdata[RAM_ADR_LO +: 7]] <= pwdata[3:0];
		end
	end

	// ************************************************
	// flags, wake enables, tone
	// ************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_enable_r   <= 4'h0;
			backup_flag     <= 1'b0;
			pulldown_select <= 2'b00;
			seconds_clear   <= 1'b0;
			s_prev_r        <= 4'h0;
			m_prev_r        <= 4'h0;
		end else begin
			s_prev_r      <= s_sync;
			m_prev_r      <= m_sync;
			seconds_clear <= state_r == ST_EXEC && run_r && op == OP_SECONDS_CLEAR; // RULE22
			if (state_r == ST_EXEC && run_r) begin
				if (op[7:4] == PFX_SIC)
					wake_enable_r <= op[3:0];                            // RULE5
				if (op[7:2] == PFX_PULLDOWN_SET)
					pulldown_select <= op[1:0];                          // RULE10
				if (op == OP_BACKUP_CLEAR)
					backup_flag <= 1'b0;                                 // RULE6
				else if (op == OP_BACKUP_SET)
					backup_flag <= 1'b1;                                 // RULE6
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tone_code      <= TONE_RST;
			tone_output_en <= 1'b0;
		end else if (state_r == ST_SECOND && (opcode_r == OP_SAS || opcode_r == OP_TABLE_TONE)) begin
			tone_code      <= rom_data;                                  // RULE8 RULE14
			tone_output_en <= rom_data[3:0] != TONE_NOTE_OFF;            // RULE9
		end
	end

	// ************************************************
	// lcd latch, control latch, output ports
	// ************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lcd_write           <= '0;
			control_latch_three <= 4'h0;
			port_p0_out         <= 4'h0;
			port_p1_out         <= 4'h0;
		end else begin
			lcd_write.we <= 1'b0;
			if (state_r == ST_EXEC && run_r && op == OP_OUT) begin
				if (stack_pointer_r <= SP_LCD_LAST)
					lcd_write <= '{1'b1, stack_pointer_r,
						{working_register_r, mem_nib}};                  // RULE11
				else if (stack_pointer_r == SP_CONTROL_LATCH_THREE)
					control_latch_three <= working_register_r;           // RULE11
				else if (stack_pointer_r == SP_P0)
					port_p0_out <= working_register_r;                   // RULE11
				else
					port_p1_out <= working_register_r;                   // RULE11
			end else if (state_r == ST_SECOND && opcode_r == OP_TABLE_WRITE) begin
				if (stack_pointer_r <= SP_LCD_LAST)
					lcd_write <= '{1'b1, stack_pointer_r, rom_data};     // RULE13
				else if (stack_pointer_r == SP_CONTROL_LATCH_THREE)
					control_latch_three <= rom_data[3:0];                // RULE13
				else if (stack_pointer_r == SP_P0)
					port_p0_out <= rom_data[3:0];                        // RULE13
				else
					port_p1_out <= rom_data[3:0];                        // RULE13
			end
		end
	end

	// ************************************************
	// checks
	// ************************************************
	wire exec_now = state_r == ST_EXEC && run_r;

	isp_step_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
		exec_now && op == OP_ISP |=> stack_pointer_r == $past(stack_pointer_r) + 4'h1)
		else $error("stack pointer increment wrong");
	halt_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
		state_r == ST_HALT && !wake |=> state_r == ST_HALT && halted)
		else $error("halt left without wake");
	backup_set_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
		exec_now && op == OP_BACKUP_SET |=> backup_flag)
		else $error("backup flag not set");
	tone_off_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
		tone_code[3:0] == TONE_NOTE_OFF |-> !tone_output_en)
		else $error("tone on with off code");
	lcd_route_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
		exec_now && op == OP_OUT && stack_pointer_r <= SP_LCD_LAST
		|=> lcd_write.we ##1 !lcd_write.we)
		else $error("lcd write pulse wrong");
	jump_target_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
		state_r == ST_SECOND && opcode_r[7:3] == PFX_JMP
		|=> program_counter_r == $past(target) && state_r == ST_EXEC)
		else $error("jump target not loaded");
	call_save_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE20
		exec_now && op[7:3] == PFX_JSR
		|=> ##1 return_stack_r == $past(program_counter_r, 2) + 11'h002)
		else $error("return address wrong");
	seconds_clear_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE22
		exec_now && op == OP_SECONDS_CLEAR |=> seconds_clear ##1 !seconds_clear || (exec_now && op == OP_SECONDS_CLEAR))
		else $error("seconds clear pulse wrong");
endmodule // nce_core

// file: nce_rom_model.sv
// program rom model on the far side of the nibble core
`timescale 1ns/100ps
module nce_rom_model (
	// rom port
	input  wire logic [10:0] rom_addr,
	output logic      [7:0]  rom_data
);
	// ************************************************
	// storage, combinational read
	// ************************************************
	// unwritten bytes read as all-ones, so a stray fetch executes a no-op
	logic [7:0] mem [0:2047];

	initial begin
		foreach (mem[i]) mem[i] = 8'hFF;
	end

	assign rom_data = mem[rom_addr];
endmodule // nce_rom_model

// file: tb_nibble_cpu_control_io_exec.sv
// self-checking testbench of the nibble core control and i/o executor
`timescale 1ns/100ps
module tb_nibble_cpu_control_io_exec;
	import nce_pkg::*;
	// ************************************************
	// signals
	// ************************************************
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic        predivider_pulse = 1'b0;
	logic [3:0]  port_s_pin = 4'hA;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [10:0] rom_addr;
	logic [7:0]  rom_data;
	logic [3:0]  port_p0_out;
	logic [3:0]  port_p1_out;
	logic [1:0]  pulldown_select;
	logic [7:0]  tone_code;
	logic        tone_output_en;
	logic        backup_flag;
	logic        halted;
	logic [31:0] rd;
	logic        err;
	int          failures = 0;
	int          check_count = 0;
	int          cycles = 0;

	always #50 pclk = ~pclk;

	nce_core u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rom_addr(rom_addr), .rom_data(rom_data),
		.port_s_pin(port_s_pin), .port_m_pin(4'h0), .port_p0_pin(4'h0),
		.port_p1_pin(4'h0), .status_word_three(4'h0),
		.predivider_pulse(predivider_pulse), .tenth_second_pulse(1'b0),
		.port_p0_out(port_p0_out), .port_p1_out(port_p1_out),
		.control_latch_three(), .lcd_write(), .backup_flag(backup_flag),
		.pulldown_select(pulldown_select), .tone_code(tone_code),
		.tone_output_en(tone_output_en), .seconds_clear(), .halted(halted));

	nce_rom_model u_rom (.rom_addr(rom_addr), .rom_data(rom_data));

	// ************************************************
	// shared tasks
	// ************************************************
	task automatic tally_and_finish;
		if (failures == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic ld(input logic [10:0] a, input logic [7:0] q[$]);
		foreach (q[i]) u_rom.mem[a + 11'(i)] = q[i];
	endtask

	// wake pulse is harmless while running; then wait for the next halt
	task automatic run_to_halt;
		@(posedge pclk);
		predivider_pulse <= 1'b1;
		@(posedge pclk);
		predivider_pulse <= 1'b0;
		while (halted !== 1'b0) @(posedge pclk);
		while (halted !== 1'b1) @(posedge pclk);
	endtask

	// ************************************************
	// timeout
	// ************************************************
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			tally_and_finish;
		end
	end

	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		repeat (5) @(posedge pclk);
		ld(11'h000, '{8'h35, 8'hEE, 8'hFC, 8'hF7, 8'hF9, 8'hFA, 8'h25, 8'hD1, 8'h08, 8'h40});
		ld(11'h040, '{8'h00, 8'hFA, 8'hFF, 8'h00, 8'h40, 8'h50, 8'h50, 8'h60});
		ld(11'h050, '{8'h00});
		ld(11'h060, '{8'hA0, 8'h7B, 8'hAF, 8'hEF, 8'hFC, 8'h00});
		ld(11'h07B, '{8'h14, 8'hFB, 8'h13});
		presetn <= 1'b1;
		check(tone_code, TONE_RST);
		apb(1'b0, 8'h0C, 32'h0);
		check(err, 1'b1);
		apb(1'b1, REG_CTRL, 32'h1);
		run_to_halt;
		check(port_p0_out, 4'h5);
		check(pulldown_select, 2'b11);
		check(backup_flag, 1'b1);
		check(tone_code, 8'h25);
		check(tone_output_en, 1'b1);
		apb(1'b0, REG_STATUS, 32'h0);
		check(rd[19:16], SP_P0);
		check(rd[26:23], 4'h1);
		check(rd[10:0], 11'h041);
		run_to_halt;
		check(tone_code, TONE_RST);
		check(tone_output_en, 1'b0);
		// a wrong branch lands on the halt at 0x050 and fails the pc check
		run_to_halt;
		check(port_p1_out, 4'hA);
		apb(1'b0, REG_STATUS, 32'h0);
		check(rd[10:0], 11'h066);
		apb(1'b0, REG_RAM, 32'h0);
		check(rd[3:0], 4'hB);
		tally_and_finish;
	end
endmodule // tb_nibble_cpu_control_io_exec
